//--- hw/pcsir_regs.sv
// status, revision, class code and cache line size for two functions
// assumes a one-cycle strobe port on i_clock and pulse event inputs
//
// Summary of operation
// - writing one clears a flag, reads harmless
// - any parity error sets bit 15
// - signalled system error sets bit 14
// - own master abort sets bit 13
// - received target abort sets bit 12
// - signalled target abort sets bit 11
// - select timing bits read fixed 01b
// - bit 8 needs perr, mastership and enable
// - bits 7 to 5 read zero
// - bit 4 reads one, capability list
// - bits 3 to 0 read zero
// - each function owns its status copy
// - revision byte fixed, writes ignored
// - class code reads 06h 07h 00h
// - cache line size writable, resets zero
// - parity response enable gates parity reaction
// - address parity on serr needs both enables
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module pcsir_regs (
  input  wire logic                           i_clock,
  input  wire logic                           i_arst_n,
  input  wire pcsir_pkg::pcsir_bus_type       i_bus,
  input  wire pcsir_pkg::pcsir_evt_type [1:0] i_evt,
  input  wire pcsir_pkg::pcsir_cmd_type [1:0] i_cmd,
  output logic [31:0]                         o_rdata,
  output logic                                o_serr,
  output logic                                o_perr,
  output logic                                o_irq
);

  pcsir_pkg::pcsir_state_type s_q;
  pcsir_pkg::pcsir_state_type s_d;
  pcsir_pkg::pcsir_cmd_type   en;
  logic [1:0][15:0]           set_v;
  logic [15:0]                clr_v;
  logic [31:0]                lanes;
  logic [31:0]                be_mask;

  // byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  function automatic logic [15:0] status_word(input logic [15:0] f);
    return (f & pcsir_pkg::STATUS_W1C) | pcsir_pkg::STATUS_FIXED;
  endfunction

  // address parity reaches serr only with both enables set
  function automatic logic serr_cause(input pcsir_pkg::pcsir_evt_type e,
                                      input pcsir_pkg::pcsir_cmd_type c);
    return c.system_error_driver_enable &
           ((e.addr_parity_err & c.parity_response_enable) | e.serr_other);
  endfunction

  function automatic logic [15:0] evt_set(input pcsir_pkg::pcsir_evt_type e,
                                          input pcsir_pkg::pcsir_cmd_type c);
    logic [15:0] v;
    v = '0;
    v[pcsir_pkg::BIT_PAR]  = e.addr_parity_err | e.data_parity_err;
    v[pcsir_pkg::BIT_SYS]  = serr_cause(e, c);
    v[pcsir_pkg::BIT_MAB]  = e.master_abort;
    v[pcsir_pkg::BIT_TAR]  = e.target_abort_rcvd;
    v[pcsir_pkg::BIT_TAS]  = e.target_abort_sent;
    v[pcsir_pkg::BIT_DPAR] = e.perr_seen & e.bus_master &
                             c.parity_response_enable;
    return v;
  endfunction

  // enables are wired-or between the two functions
  assign en    = i_cmd[0] | i_cmd[1];
  assign be_mask = lane_mask(i_bus.byte_en);
  assign lanes   = be_mask & i_bus.wdata;

  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;
    s_d.serr  = 1'b0;
    s_d.perr  = 1'b0;
    clr_v     = '0;
    for (int f = 0; f < 2; f++) begin
      set_v[f] = evt_set(i_evt[f], en);
      s_d.serr = s_d.serr | serr_cause(i_evt[f], en);
      s_d.perr = s_d.perr |
                 (i_evt[f].data_parity_err & en.parity_response_enable);
      if (i_bus.wr && i_bus.func == f[0] &&
          hit(i_bus.addr, pcsir_pkg::OFS_STATUS)) begin
        clr_v = lanes[pcsir_pkg::STATUS_LSB +: 16];
      end else begin
        clr_v = '0;
      end
      // a new event in the clearing cycle survives the clear
      s_d.flags[f] = ((s_q.flags[f] & ~clr_v) | set_v[f]) &
                     pcsir_pkg::STATUS_W1C;
      if (i_bus.wr && i_bus.func == f[0] && i_bus.byte_en[0] &&
          hit(i_bus.addr, pcsir_pkg::OFS_CACHE)) begin
        s_d.cache[f] = i_bus.wdata[7:0];
      end
    end
    if (i_bus.wr && hit(i_bus.addr, pcsir_pkg::OFS_MASK)) begin
      s_d.mask = (s_q.mask & ~be_mask[15:0]) | lanes[15:0];
    end
    s_d.evt = s_q.evt;
    if (i_bus.rd && hit(i_bus.addr, pcsir_pkg::OFS_EVT)) begin
      s_d.evt = '0;
    end
    s_d.evt = (s_d.evt | set_v[0] | set_v[1]) & pcsir_pkg::STATUS_W1C;
    if (i_bus.rd) begin
      // writes to revision and class dword have no target, so they vanish
      if (hit(i_bus.addr, pcsir_pkg::OFS_STATUS)) begin
        s_d.rdata[pcsir_pkg::STATUS_LSB +: 16] =
          status_word(s_q.flags[i_bus.func]);
      end else if (hit(i_bus.addr, pcsir_pkg::OFS_REVISION)) begin
        s_d.rdata = {pcsir_pkg::CLASS_CODE,
                     pcsir_pkg::REVISION};
      end else if (hit(i_bus.addr, pcsir_pkg::OFS_CACHE)) begin
        s_d.rdata[7:0] = s_q.cache[i_bus.func];
      end else if (hit(i_bus.addr, pcsir_pkg::OFS_EVT)) begin
        s_d.rdata[15:0] = s_q.evt;
      end else if (hit(i_bus.addr, pcsir_pkg::OFS_MASK)) begin
        s_d.rdata[15:0] = s_q.mask;
      end
      s_d.rdata = s_d.rdata & lane_mask(i_bus.byte_en);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q.flags <= {pcsir_pkg::FLAGS_RESET, pcsir_pkg::FLAGS_RESET};
      s_q.cache <= {pcsir_pkg::CACHE_RESET, pcsir_pkg::CACHE_RESET};
      s_q.evt   <= pcsir_pkg::FLAGS_RESET;
      s_q.mask  <= pcsir_pkg::MASK_RESET;
      s_q.rdata <= '0;
      s_q.serr  <= 1'b0;
      s_q.perr  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_serr  = s_q.serr;
  assign o_perr  = s_q.perr;
  assign o_irq   = |(s_q.evt & s_q.mask);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence rd_of(logic [7:0] ofs, logic [3:0] be);
    i_bus.rd && hit(i_bus.addr, ofs) && i_bus.byte_en == be;
  endsequence

  sequence f0_clear(int b);
    i_bus.wr && !i_bus.func && hit(i_bus.addr, pcsir_pkg::OFS_STATUS) &&
    i_bus.byte_en[3:2] == 2'b11 && i_bus.wdata[pcsir_pkg::STATUS_LSB + b];
  endsequence

  sequence st_any;
    i_bus.rd && hit(i_bus.addr, pcsir_pkg::OFS_STATUS) &&
    i_bus.byte_en[3:2] == 2'b11;
  endsequence

  // a write of zeros to function 0 status must be harmless
  sequence zero_wr;
    i_bus.wr && !i_bus.func && hit(i_bus.addr, pcsir_pkg::OFS_STATUS) &&
    i_bus.wdata[31:16] == 16'h0000;
  endsequence

  parity_flag_a: assert property (
    i_evt[0].data_parity_err |=> s_q.flags[0][pcsir_pkg::BIT_PAR])
    else $error("parity event did not set bit 15");

  system_error_signalled_flag_a: assert property (
    serr_cause(i_evt[0], en) |=> o_serr && s_q.flags[0][pcsir_pkg::BIT_SYS])
    else $error("system error not signalled and flagged together");

  serr_gate_a: assert property (
    $rose(o_serr) |-> $past(en.system_error_driver_enable))
    else $error("serr driven without driver enable");

  mab_flag_a: assert property (
    i_evt[0].master_abort
    |=> s_q.flags[0][pcsir_pkg::BIT_MAB])
    else $error("master abort did not set bit 13");

  tar_flag_a: assert property (
    i_evt[1].target_abort_rcvd
    |=> s_q.flags[1][pcsir_pkg::BIT_TAR])
    else $error("received target abort did not set bit 12");

  tas_flag_a: assert property (
    i_evt[0].target_abort_sent
    |=> s_q.flags[0][pcsir_pkg::BIT_TAS])
    else $error("signalled target abort did not set bit 11");

  dpar_cause_a: assert property (
    $rose(s_q.flags[0][pcsir_pkg::BIT_DPAR]) |->
    $past(i_evt[0].perr_seen && i_evt[0].bus_master &&
          en.parity_response_enable))
    else $error("data parity flag set without all conditions");

  fixed_bits_a: assert property (
    rd_of(pcsir_pkg::OFS_STATUS, 4'hf) |=>
    (o_rdata[26:16] & 11'h6ff) == 11'h210)
    else $error("status fixed bits wrong");

  flag_clear_a: assert property (
    f0_clear(pcsir_pkg::BIT_MAB) ##0 !i_evt[0].master_abort
    |=> !s_q.flags[0][pcsir_pkg::BIT_MAB])
    else $error("write one did not clear flag");

  flag_hold_a: assert property (
    !i_bus.wr |=> s_q.flags[0] == ($past(s_q.flags[0]) | $past(set_v[0])))
    else $error("flag changed without write");

  class_read_a: assert property (
    rd_of(pcsir_pkg::OFS_REVISION, 4'hf) |=> ##0
    o_rdata == {24'h060700, pcsir_pkg::REVISION} ##1 o_rdata == '0 ||
    $past(i_bus.rd))
    else $error("revision or class code wrong");

  cache_write_a: assert property (
    i_bus.wr && !i_bus.func && i_bus.byte_en[0] &&
    hit(i_bus.addr, pcsir_pkg::OFS_CACHE) |=>
    s_q.cache[0] == $past(i_bus.wdata[7:0]))
    else $error("cache line size not written");

  sel_timing_a: assert property (
    st_any
    |=> o_rdata[26:25] == 2'b01)
    else $error("select timing field not 01b");

  no_caps_a: assert property (
    st_any
    |=> o_rdata[23:21] == 3'b000)
    else $error("status bits 7 to 5 not zero");

  cap_list_a: assert property (
    st_any
    |=> o_rdata[20])
    else $error("capability list bit not set");

  reserved_low_a: assert property (
    st_any
    |=> o_rdata[19:16] == 4'h0)
    else $error("reserved status bits not zero");

  cmd_half_zero_a: assert property (
    rd_of(pcsir_pkg::OFS_STATUS, 4'hf)
    |=> o_rdata[15:0] == 16'h0000)
    else $error("low half of status dword not zero");

  rdata_idle_a: assert property (
    !i_bus.rd
    |=> o_rdata == 32'h0000_0000)
    else $error("read data present without a read");

  rdata_lane_a: assert property (
    i_bus.rd && !i_bus.byte_en[3]
    |=> o_rdata[31:24] == 8'h00)
    else $error("disabled byte lane not zero");

  read_quiet_a: assert property (
    i_bus.rd && i_evt[0] == '0
    |=> $stable(s_q.flags[0]))
    else $error("read disturbed status flags");

  zero_write_a: assert property (
    zero_wr ##0 i_evt[0] == '0
    |=> $stable(s_q.flags[0]))
    else $error("writing zero changed a flag");

  other_func_a: assert property (
    i_bus.wr && i_bus.func && i_evt[0] == '0
    |=> $stable(s_q.flags[0]))
    else $error("function 1 write changed function 0 flags");

  par_flag_one_a: assert property (
    i_evt[1].addr_parity_err
    |=> s_q.flags[1][pcsir_pkg::BIT_PAR])
    else $error("address parity did not set bit 15");

  par_data_one_a: assert property (
    i_evt[1].data_parity_err
    |=> s_q.flags[1][pcsir_pkg::BIT_PAR])
    else $error("data parity did not set bit 15");

  sys_flag_one_a: assert property (
    serr_cause(i_evt[1], en)
    |=> s_q.flags[1][pcsir_pkg::BIT_SYS])
    else $error("system error not flagged in function 1");

  sys_cause_a: assert property (
    $rose(s_q.flags[0][pcsir_pkg::BIT_SYS])
    |-> $past(serr_cause(i_evt[0], en)))
    else $error("system error flag set without cause");

  dpar_set_a: assert property (
    i_evt[1].perr_seen && i_evt[1].bus_master && en.parity_response_enable
    |=> s_q.flags[1][pcsir_pkg::BIT_DPAR])
    else $error("data parity flag not set");

  dpar_cause_one_a: assert property (
    $rose(s_q.flags[1][pcsir_pkg::BIT_DPAR])
    |-> $past(i_evt[1].perr_seen && i_evt[1].bus_master))
    else $error("function 1 data parity flag without cause");

  perr_enable_a: assert property (
    o_perr
    |-> $past(en.parity_response_enable))
    else $error("perr pulse without parity response enable");

  perr_quiet_a: assert property (
    !en.parity_response_enable
    |=> !o_perr)
    else $error("parity error not ignored while disabled");

  serr_quiet_a: assert property (
    !en.system_error_driver_enable
    |=> !o_serr)
    else $error("serr pulse with driver disabled");

  addr_par_gate_a: assert property (
    !en.parity_response_enable && !i_evt[0].serr_other &&
    !i_evt[1].serr_other |=> !o_serr)
    else $error("address parity reached serr without parity enable");

  cache_hold_a: assert property (
    !(i_bus.wr && hit(i_bus.addr, pcsir_pkg::OFS_CACHE))
    |=> $stable(s_q.cache))
    else $error("cache line size changed without a write");

  cache_lane_a: assert property (
    i_bus.wr && !i_bus.byte_en[0]
    |=> $stable(s_q.cache))
    else $error("cache line size written with lane off");

  cache_one_a: assert property (
    i_bus.wr && i_bus.func && i_bus.byte_en[0] &&
    hit(i_bus.addr, pcsir_pkg::OFS_CACHE) |=>
    s_q.cache[1] == $past(i_bus.wdata[7:0]))
    else $error("function 1 cache line size not written");

  cache_read_a: assert property (
    i_bus.rd && !i_bus.func && i_bus.byte_en[0] &&
    hit(i_bus.addr, pcsir_pkg::OFS_CACHE) |=>
    o_rdata[7:0] == $past(s_q.cache[0]))
    else $error("cache line size read back wrong");

  rev_read_a: assert property (
    rd_of(pcsir_pkg::OFS_REVISION, 4'hf)
    |=> o_rdata[7:0] == pcsir_pkg::REVISION)
    else $error("revision byte wrong");

  rev_write_a: assert property (
    i_bus.wr && hit(i_bus.addr, pcsir_pkg::OFS_REVISION)
    |=> $stable(s_q.cache) && $stable(s_q.mask))
    else $error("write to revision dword had an effect");

  evt_clear_a: assert property (
    rd_of(pcsir_pkg::OFS_EVT, 4'hf) ##0 i_evt == '0
    |=> s_q.evt == 16'h0000)
    else $error("event status not cleared by read");

  mask_write_a: assert property (
    i_bus.wr && hit(i_bus.addr, pcsir_pkg::OFS_MASK) &&
    i_bus.byte_en[1:0] == 2'b11 |=>
    s_q.mask == $past(i_bus.wdata[15:0]))
    else $error("interrupt mask not written");

endmodule

//--- hw/pcsir_pkg.sv
// constants and carrier types for the configuration status/id register bank
// assumes a byte-addressed dword config port, one function select bit
package pcsir_pkg;

  // register byte offsets, matched by dword; narrower registers sit in byte lanes
  localparam logic [7:0] OFS_STATUS   = 8'h06;
  localparam logic [7:0] OFS_REVISION = 8'h08;
  localparam logic [7:0] OFS_CLASS    = 8'h09;
  localparam logic [7:0] OFS_CACHE    = 8'h0c;
  localparam logic [7:0] OFS_EVT      = 8'h40;
  localparam logic [7:0] OFS_MASK     = 8'h44;

  localparam int STATUS_LSB = 16;
  localparam int CLASS_LSB  = 8;

  localparam int BIT_PAR  = 15;
  localparam int BIT_SYS  = 14;
  localparam int BIT_MAB  = 13;
  localparam int BIT_TAR  = 12;
  localparam int BIT_TAS  = 11;
  localparam int BIT_DPAR = 8;

  localparam logic [15:0] STATUS_W1C   = 16'hf900;
  localparam logic [15:0] STATUS_FIXED = 16'h0210;
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  localparam logic [7:0]  CACHE_RESET  = 8'h00;
  localparam logic [23:0] CLASS_CODE   = 24'h060700;
  // revision value is arbitrary
  localparam logic [7:0]  REVISION     = 8'h5a;

  typedef struct packed {
    logic        func;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  byte_en;
    logic        wr;
    logic        rd;
  } pcsir_bus_type;

  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic perr_seen;
    logic bus_master;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
    logic serr_other;
  } pcsir_evt_type;

  typedef struct packed {
    logic system_error_driver_enable;
    logic parity_response_enable;
  } pcsir_cmd_type;

  typedef struct packed {
    logic [1:0][15:0] flags;
    logic [1:0][7:0]  cache;
    logic [15:0]      evt;
    logic [15:0]      mask;
    logic [31:0]      rdata;
    logic             serr;
    logic             perr;
  } pcsir_state_type;

endpackage

//--- tb/pcsir_host_model.sv
// host config master: one-cycle strobes on the register port
// assumes a slave without wait states and read data one cycle later
`timescale 1ns/1ps
module pcsir_host_model (
  input  wire logic                i_clock,
  input  wire logic [31:0]         i_rdata,
  output pcsir_pkg::pcsir_bus_type o_bus
);
  initial o_bus = '0;
  // write ones to clear flags; lanes picked by byte enables
  task automatic wr(input logic f, input logic [7:0] a,
                    input logic [3:0] be, input logic [31:0] d);
    @(posedge i_clock);
    o_bus <= '{f, a, d, be, 1'b1, 1'b0};
    @(posedge i_clock);
    o_bus.wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so take it there
  task automatic rd(input logic f, input logic [7:0] a,
                    input logic [3:0] be, output logic [31:0] d);
    @(posedge i_clock);
    o_bus <= '{f, a, 32'h0, be, 1'b0, 1'b1};
    @(posedge i_clock);
    o_bus.rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

//--- tb/pci_config_status_id_regs_test.sv
// self-checking bench for the status, id and cache line registers
// assumes the host model as bus master and pulses on the event inputs
`timescale 1ns/1ps
module pci_config_status_id_regs_test;
  logic                           i_clock = 1'b0;
  logic                           i_arst_n = 1'b0;
  pcsir_pkg::pcsir_bus_type       bus;
  pcsir_pkg::pcsir_evt_type [1:0] evt = '0;
  pcsir_pkg::pcsir_cmd_type [1:0] cmd = '0;
  logic [31:0]                    rdata;
  logic [31:0]                    d;
  logic                           serr;
  logic                           perr;
  logic                           irq;
  logic                           f;
  int                             err_total = 0;
  int                             cmp_count = 0;
  logic [7:0]  ev [10] = '{8'h08, 8'h04, 8'h02, 8'h80, 8'h80,
                           8'h70, 8'h70, 8'h30, 8'h01, 8'h01};
  logic [1:0]  cm [10] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h1,
                           2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [15:0] st [10] = '{16'h2210, 16'h1210, 16'h0a10, 16'hc210,
                           16'h8210, 16'h8310, 16'h8210, 16'h0310,
                           16'h4210, 16'h0210};
  logic [9:0]  sx = 10'b0100001000;
  logic [9:0]  px = 10'b0000100000;

  pcsir_regs i_pcsir_regs (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_bus(bus), .i_evt(evt), .i_cmd(cmd), .o_rdata(rdata),
    .o_serr(serr), .o_perr(perr), .o_irq(irq));
  pcsir_host_model i_pcsir_host_model (.i_clock(i_clock),
    .i_rdata(rdata), .o_bus(bus));

  initial begin
    forever #5 i_clock = ~i_clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one event pulse with the command enables of both functions set alike
  task automatic pulse(input logic g, input logic [7:0] e,
                       input logic [1:0] c, input logic s, input logic p);
    @(posedge i_clock);
    evt[g] <= pcsir_pkg::pcsir_evt_type'(e);
    cmd <= {c, c};
    @(posedge i_clock);
    evt[g] <= '0;
    #1;
    check(serr, s);
    check(perr, p);
  endtask

  initial begin
    #200us;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge i_clock);
    i_arst_n <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      i_pcsir_host_model.rd(g[0], 8'h04, 4'hf, d);
      check(d, 32'h02100000);
      i_pcsir_host_model.rd(g[0], 8'h0c, 4'hf, d);
      check(d, 32'h0);
    end
    for (int i = 0; i < 10; i++) begin
      f = i[0];
      pulse(f, ev[i], cm[i], sx[i], px[i]);
      i_pcsir_host_model.rd(f, 8'h04, 4'hc, d);
      check(d, {st[i], 16'h0});
      i_pcsir_host_model.rd(~f, 8'h04, 4'hc, d);
      check(d, 32'h02100000);
      i_pcsir_host_model.wr(f, 8'h04, 4'hc, 32'h0);
      i_pcsir_host_model.rd(f, 8'h04, 4'hc, d);
      check(d, {st[i], 16'h0});
      i_pcsir_host_model.wr(f, 8'h04, 4'hc, 32'hffff0000);
      i_pcsir_host_model.rd(f, 8'h04, 4'hc, d);
      check(d, 32'h02100000);
    end
    // interrupt: masked event stays quiet, unmasking raises the level
    i_pcsir_host_model.rd(1'b0, 8'h40, 4'hf, d);
    i_pcsir_host_model.wr(1'b0, 8'h44, 4'h3, 32'h1000);
    pulse(1'b0, 8'h08, 2'h0, 1'b0, 1'b0);
    check(irq, 1'b0);
    i_pcsir_host_model.wr(1'b0, 8'h44, 4'h3, 32'h2000);
    #1;
    check(irq, 1'b1);
    i_pcsir_host_model.rd(1'b0, 8'h40, 4'hf, d);
    check(d, 32'h00002000);
    check(irq, 1'b0);
    i_pcsir_host_model.rd(1'b0, 8'h40, 4'hf, d);
    check(d, 32'h0);
    // cache line per function, byte lanes, read-only and unmapped places
    i_pcsir_host_model.wr(1'b0, 8'h0c, 4'h1, 32'hffffffa5);
    i_pcsir_host_model.wr(1'b1, 8'h0c, 4'h1, 32'h0000003c);
    i_pcsir_host_model.wr(1'b0, 8'h0c, 4'h0, 32'h000000ff);
    i_pcsir_host_model.rd(1'b0, 8'h0c, 4'hf, d);
    check(d, 32'h000000a5);
    i_pcsir_host_model.rd(1'b1, 8'h0c, 4'hf, d);
    check(d, 32'h0000003c);
    i_pcsir_host_model.wr(1'b1, 8'h08, 4'hf, 32'hffffffff);
    i_pcsir_host_model.rd(1'b1, 8'h08, 4'hf, d);
    check(d, {24'h060700, pcsir_pkg::REVISION});
    i_pcsir_host_model.rd(1'b1, 8'h04, 4'h4, d);
    check(d, 32'h00100000);
    i_pcsir_host_model.rd(1'b0, 8'h80, 4'hf, d);
    check(d, 32'h0);
    end_sim();
  end
endmodule
